// file: src/board_user_io_lcd_port.sv
// Contract
// - General buttons read low while pressed.
// - Two general buttons plus one reset button.
// - Reset button pressed resets whole design.
// - Reset button also readable as input.
// - Lamp outputs low light, high extinguish.
// - Read/write high reads, module drives bus.
// - Enable pulses high; module acts falling.
// - Bus usable eight or four bits wide.
// - Addressing assumes two lines, sixteen characters.
//
// The implementer's own choices: the register addresses and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module board_user_io_lcd_port (
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    input  wire logic        wb_cyc_i,
    input  wire logic        wb_stb_i,
    input  wire logic        wb_we_i,
    input  wire logic [7:0]  wb_adr_i,
    input  wire logic [3:0]  wb_sel_i,
    input  wire logic [31:0] wb_dat_i,
    output logic      [31:0] wb_dat_o,
    output logic             wb_ack_o,
    input  wire logic        general_button_a_n_i,
    input  wire logic        general_button_b_n_i,
    input  wire logic        design_reset_button_n_i,
    output logic             indicator_lamp_0_n_o,
    output logic             indicator_lamp_1_n_o,
    output logic             indicator_lamp_2_n_o,
    output logic             indicator_lamp_3_n_o,
    output logic             text_display_select_o,
    output logic             text_display_read_write_o,
    output logic             text_display_enable_o,
    output logic             text_display_chip_select_n_o,
    input  wire logic [7:0]  module_data_lines_i,
    output logic      [7:0]  module_data_lines_o,
    output logic      [7:0]  module_data_lines_oe_n_o
);
    import user_io_pkg::*;

    typedef struct packed {
        eng_state_t  st;
        logic [7:0]  cnt;
        logic        nib;
        logic [7:0]  word;
        logic        dsel;
        logic        rw;
        logic        e;
        logic        cs_n;
        logic [7:0]  dout;
        logic [7:0]  oe_n;
        logic        pend;
        logic [7:0]  pend_ch;
        logic [7:0]  rdata;
        logic        nib_mode;
        logic [3:0]  lamp_n;
        logic [2:0]  pressed;
        logic        ack;
        logic [31:0] rdat;
    } io_state_t;

    io_state_t  s_reg;
    io_state_t  s_next;
    logic [2:0] btn_q;
    logic [7:0] bus_q;
    logic       rst_sys;
    logic       req;

    pin_sync #(.WIDTH(3)) u_btn_sync (
        .clk_i (clk_i),
        .d_i   ({design_reset_button_n_i, general_button_b_n_i, general_button_a_n_i}),
        .q_o   (btn_q)
    );

    pin_sync #(.WIDTH(8)) u_bus_sync (
        .clk_i (clk_i),
        .d_i   (module_data_lines_i),
        .q_o   (bus_q)
    );

    // Lines 7:4 carry the nibbles in narrow mode, high nibble first
    function automatic logic [7:0] lane(input logic [7:0] w, input logic narrow,
                                        input logic second);
        if (!narrow) begin
            lane = w;
        end else begin
            lane = {(second ? w[3:0] : w[7:4]), 4'h0};
        end
    endfunction

    function automatic io_state_t start_xfer(input io_state_t x, input logic ds,
                                             input logic rd, input logic [7:0] w);
        start_xfer      = x;
        start_xfer.st   = S_SETUP;
        start_xfer.cnt  = SETUP_CYC - 8'h01;
        start_xfer.dsel = ds;
        start_xfer.rw   = rd;
        start_xfer.word = w;
        start_xfer.nib  = 1'b0;
        start_xfer.cs_n = 1'b0;
        start_xfer.oe_n = {8{rd}};
        start_xfer.dout = rd ? 8'h00 : lane(w, x.nib_mode, 1'b0);
    endfunction

    function automatic logic [7:0] char_addr(input logic line, input logic [3:0] col);
        char_addr = SET_ADDR_OP | (line ? LINE1_BASE : 8'h00) | {4'h0, col};
    endfunction

    assign rst_sys = rst_i || !btn_q[2];
    assign req     = wb_cyc_i && wb_stb_i && !s_reg.ack;

    always_comb begin
        s_next         = s_reg;
        s_next.ack     = 1'b0;
        s_next.pressed = ~btn_q;

        case (s_reg.st)
            S_IDLE: begin
                s_next.cs_n = 1'b1;
            end
            S_SETUP: begin
                if (s_reg.cnt == 8'h00) begin
                    s_next.st  = S_PULSE;
                    s_next.e   = 1'b1;
                    s_next.cnt = PULSE_CYC - 8'h01;
                end else begin
                    s_next.cnt = s_reg.cnt - 8'h01;
                end
            end
            S_PULSE: begin
                if (s_reg.cnt == 8'h00) begin
                    s_next.e   = 1'b0;
                    s_next.st  = S_HOLD;
                    s_next.cnt = HOLD_CYC - 8'h01;
                    // Sampled while enable is still high; the pulse outlasts the sync delay
                    if (s_reg.rw) begin
                        if (!s_reg.nib_mode) begin
                            s_next.rdata = bus_q;
                        end else if (!s_reg.nib) begin
                            s_next.rdata[7:4] = bus_q[7:4];
                        end else begin
                            s_next.rdata[3:0] = bus_q[7:4];
                        end
                    end
                end else begin
                    s_next.cnt = s_reg.cnt - 8'h01;
                end
            end
            S_HOLD: begin
                if (s_reg.cnt != 8'h00) begin
                    s_next.cnt = s_reg.cnt - 8'h01;
                end else if (s_reg.nib_mode && !s_reg.nib) begin
                    s_next.nib  = 1'b1;
                    s_next.st   = S_SETUP;
                    s_next.cnt  = SETUP_CYC - 8'h01;
                    s_next.dout = s_reg.rw ? 8'h00 : lane(s_reg.word, 1'b1, 1'b1);
                end else if (s_reg.pend) begin
                    // Chip select stays low between address and character
                    s_next      = start_xfer(s_reg, 1'b1, 1'b0, s_reg.pend_ch);
                    s_next.pend = 1'b0;
                end else begin
                    s_next.st   = S_IDLE;
                    s_next.cs_n = 1'b1;
                    s_next.oe_n = 8'hff;
                    s_next.dsel = 1'b0;
                    s_next.rw   = 1'b0;
                    s_next.dout = 8'h00;
                end
            end
            default: begin
                s_next.st = S_IDLE;
            end
        endcase

        if (req) begin
            s_next.ack = 1'b1;
            case (wb_adr_i)
                OFS_BUTTON: s_next.rdat = {25'h0, btn_q, 1'b0, s_reg.pressed};
                OFS_LAMP:   s_next.rdat = {28'h0, ~s_reg.lamp_n};
                OFS_XFER:   s_next.rdat = {22'h0, s_reg.nib_mode, s_reg.st != S_IDLE,
                                           s_reg.rdata};
                OFS_MODE:   s_next.rdat = {31'h0, s_reg.nib_mode};
                default:    s_next.rdat = 32'h0;
            endcase
            if (wb_we_i) begin
                case (wb_adr_i)
                    OFS_LAMP: begin
                        if (wb_sel_i[0]) begin
                            s_next.lamp_n = ~wb_dat_i[3:0];
                        end
                    end
                    OFS_MODE: begin
                        // Must match the width set in the module by software
                        if (wb_sel_i[0] && s_reg.st == S_IDLE) begin
                            s_next.nib_mode = wb_dat_i[0];
                        end
                    end
                    OFS_XFER: begin
                        // Dropped while busy; software polls the busy bit first
                        if (wb_sel_i[1:0] == 2'b11 && s_reg.st == S_IDLE) begin
                            s_next = start_xfer(s_next, wb_dat_i[XFER_SEL_BIT],
                                                wb_dat_i[XFER_RD_BIT], wb_dat_i[7:0]);
                        end
                    end
                    OFS_CHAR: begin
                        if (wb_sel_i[1:0] == 2'b11 && s_reg.st == S_IDLE) begin
                            s_next = start_xfer(s_next, 1'b0, 1'b0,
                                char_addr(wb_dat_i[CHAR_LINE_BIT],
                                          wb_dat_i[CHAR_COL_LSB+3:CHAR_COL_LSB]));
                            s_next.pend    = 1'b1;
                            s_next.pend_ch = wb_dat_i[7:0];
                        end
                    end
                    default: begin
                    end
                endcase
            end
        end

        if (rst_sys) begin
            s_next          = '0;
            s_next.st       = S_IDLE;
            s_next.cs_n     = 1'b1;
            s_next.oe_n     = 8'hff;
            s_next.lamp_n   = LAMP_RST;
            s_next.nib_mode = NIBBLE_RST;
            s_next.pressed  = ~btn_q;
        end
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    assign wb_dat_o                     = s_reg.rdat;
    assign wb_ack_o                     = s_reg.ack;
    assign indicator_lamp_0_n_o         = s_reg.lamp_n[0];
    assign indicator_lamp_1_n_o         = s_reg.lamp_n[1];
    assign indicator_lamp_2_n_o         = s_reg.lamp_n[2];
    assign indicator_lamp_3_n_o         = s_reg.lamp_n[3];
    assign text_display_select_o        = s_reg.dsel;
    assign text_display_read_write_o    = s_reg.rw;
    assign text_display_enable_o        = s_reg.e;
    assign text_display_chip_select_n_o = s_reg.cs_n;
    assign module_data_lines_o          = s_reg.dout;
    assign module_data_lines_oe_n_o     = s_reg.oe_n;

    a_lamp_write: assert property (@(posedge clk_i) disable iff (rst_sys)
        req && wb_we_i && wb_adr_i == OFS_LAMP && wb_sel_i[0]
        |=> {indicator_lamp_3_n_o, indicator_lamp_2_n_o, indicator_lamp_1_n_o,
             indicator_lamp_0_n_o} == ~$past(wb_dat_i[3:0]))
        else $error("lamp outputs not inverse of written value");

    a_reset_button: assert property (@(posedge clk_i)
        !btn_q[2] |=> s_reg.st == S_IDLE && s_reg.lamp_n == LAMP_RST && !wb_ack_o)
        else $error("reset button did not reset the design");

    a_button_level: assert property (@(posedge clk_i) disable iff (rst_i)
        1'b1 |=> s_reg.pressed[1:0] == ~$past(btn_q[1:0]))
        else $error("button pressed flags wrong polarity");

    a_read_release: assert property (@(posedge clk_i) disable iff (rst_sys)
        text_display_read_write_o && !text_display_chip_select_n_o
        |-> module_data_lines_oe_n_o == 8'hff)
        else $error("bus driven during display read");

    a_enable_pulse: assert property (@(posedge clk_i) disable iff (rst_sys)
        $rose(text_display_enable_o) |-> ##50 $fell(text_display_enable_o))
        else $error("enable pulse length wrong");

    a_stable_enable: assert property (@(posedge clk_i) disable iff (rst_sys)
        $fell(text_display_enable_o) |-> ($stable(text_display_select_o)
        && $stable(text_display_read_write_o) && $stable(module_data_lines_o))
        ##1 ($stable(text_display_select_o) && $stable(module_data_lines_o)))
        else $error("controls changed around enable fall");

    a_cs_access: assert property (@(posedge clk_i) disable iff (rst_sys)
        1'b1 |-> text_display_chip_select_n_o == (s_reg.st == S_IDLE))
        else $error("chip select not low for exactly the access");

    a_narrow_lanes: assert property (@(posedge clk_i) disable iff (rst_sys)
        s_reg.nib_mode && text_display_enable_o |-> module_data_lines_o[3:0] == 4'h0)
        else $error("low lines used in narrow mode");

    a_char_addr: assert property (@(posedge clk_i) disable iff (rst_sys)
        s_reg.pend && s_reg.st == S_SETUP |-> !s_reg.dsel && s_reg.word[7]
        && s_reg.word[5:4] == 2'b00)
        else $error("character address outside two by sixteen");

    a_ack_once: assert property (@(posedge clk_i) disable iff (rst_sys)
        wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule
`default_nettype wire

// file: src/user_io_pkg.sv
`default_nettype none
package user_io_pkg;
    localparam int CLK_MHZ = 100;
    // Bus byte offsets
    localparam logic [7:0] OFS_BUTTON = 8'h00;
    localparam logic [7:0] OFS_LAMP   = 8'h04;
    localparam logic [7:0] OFS_XFER   = 8'h08;
    localparam logic [7:0] OFS_MODE   = 8'h0c;
    localparam logic [7:0] OFS_CHAR   = 8'h10;
    // Field positions
    localparam int XFER_SEL_BIT  = 8;
    localparam int XFER_RD_BIT   = 9;
    localparam int STAT_BUSY_BIT = 8;
    localparam int STAT_MODE_BIT = 9;
    localparam int CHAR_COL_LSB  = 8;
    localparam int CHAR_LINE_BIT = 12;
    localparam int BTN_RAW_LSB   = 4;
    // Reset values
    localparam logic [3:0] LAMP_RST    = 4'hf;
    localparam logic       NIBBLE_RST  = 1'b0;
    // Character display geometry and address instruction
    localparam int         LINE_CHARS  = 16;
    localparam int         LINE_COUNT  = 2;
    localparam logic [7:0] SET_ADDR_OP = 8'h80;
    localparam logic [7:0] LINE1_BASE  = 8'h40;
    // Strobe timing, least times in ns
    localparam int T_SETUP_NS = 60;
    localparam int T_PULSE_NS = 500;
    localparam int T_HOLD_NS  = 40;
    localparam logic [7:0] SETUP_CYC = 8'((T_SETUP_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] PULSE_CYC = 8'((T_PULSE_NS * CLK_MHZ + 999) / 1000);
    localparam logic [7:0] HOLD_CYC  = 8'((T_HOLD_NS * CLK_MHZ + 999) / 1000);

    typedef enum logic [3:0] {
        S_IDLE  = 4'b0001,
        S_SETUP = 4'b0010,
        S_PULSE = 4'b0100,
        S_HOLD  = 4'b1000
    } eng_state_t;
endpackage
`default_nettype wire

// file: src/pin_sync.sv
`timescale 1ns/1ps
`default_nettype none
module pin_sync #(
    parameter int WIDTH = 1
) (
    input  wire logic             clk_i,
    input  wire logic [WIDTH-1:0] d_i,
    output logic      [WIDTH-1:0] q_o
);
    typedef struct packed {
        logic [WIDTH-1:0] meta;
        logic [WIDTH-1:0] stable;
    } sync_t;

    sync_t s_reg;
    sync_t s_next;

    // No reset: a reset here would hide the button that causes it
    always_comb begin
        s_next        = s_reg;
        s_next.meta   = d_i;
        s_next.stable = s_reg.meta;
    end

    always_ff @(posedge clk_i) begin
        s_reg <= s_next;
    end

    assign q_o = s_reg.stable;
endmodule
`default_nettype wire

// file: verif/text_display_model.sv
`timescale 1ns/1ps
`default_nettype none
module text_display_model (
    input  wire logic        clk_i,
    input  wire logic        select_i,
    input  wire logic        read_write_i,
    input  wire logic        enable_i,
    input  wire logic        chip_select_n_i,
    input  wire logic        nibble_i,
    input  wire logic [7:0]  read_value_i,
    input  wire logic [7:0]  lines_i,
    output logic      [7:0]  lines_o,
    output logic      [15:0] log_o,
    output logic      [1:0]  sel_log_o,
    output logic      [7:0]  count_o
);
    logic       half = 1'b0;
    logic [3:0] hi = 4'h0;
    logic [7:0] held = 8'h00;
    initial begin
        log_o = 16'h0000;
        sel_log_o = 2'b00;
        count_o = 8'h00;
    end
    // Released lines toggle every cycle so a stale byte cannot pass for a read
    always_comb begin
        if (!chip_select_n_i && read_write_i) begin
            lines_o = (nibble_i && half) ? {read_value_i[3:0], read_value_i[7:4]} : read_value_i;
        end else begin
            lines_o = ~held;
        end
    end
    always @(posedge clk_i) held <= lines_o;
    always @(posedge chip_select_n_i) half <= 1'b0;
    // Module acts only on the falling strobe
    always @(negedge enable_i) begin
        if (!read_write_i) begin
            if (nibble_i && !half) begin
                hi <= lines_i[7:4];
            end else begin
                log_o <= {log_o[7:0], nibble_i ? {hi, lines_i[7:4]} : lines_i};
                sel_log_o <= {sel_log_o[0], select_i};
                count_o <= count_o + 8'h01;
            end
        end
        if (nibble_i) half <= ~half;
    end
endmodule
`default_nettype wire

// file: verif/board_user_io_lcd_port_tb.sv
`timescale 1ns/1ps
`default_nettype none
module board_user_io_lcd_port_tb;
    import user_io_pkg::*;
    typedef struct {logic a; logic b; logic [3:0] lamp; logic [31:0] btn; logic [3:0] pins;} row_t;
    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc = 1'b0, stb = 1'b0, we = 1'b0, nib = 1'b0;
    logic        btn_a = 1'b1, btn_b = 1'b1, rst_btn = 1'b1, cs_prev = 1'b1;
    logic [7:0]  adr = 8'h00, rdval = 8'h00, dout, oe_n, model_o, count, c0;
    logic [31:0] wdat = 32'h0, rdat, q;
    logic        ack, sel_o, rw_o, en_o, cs_n_o;
    logic [3:0]  pins;
    logic [3:0]  sel = 4'hf;
    logic [15:0] log;
    logic [1:0]  sel_log;
    int          n_mismatch = 0, check_count = 0, hi_cnt = 0, cs_rise = 0, ticks = 0, r0;
    wire logic [7:0] bus = (oe_n & model_o) | (~oe_n & dout);
    row_t rows[4] = '{'{1'b1, 1'b1, 4'h0, 32'h70, 4'hf}, '{1'b0, 1'b1, 4'h5, 32'h61, 4'ha},
                      '{1'b1, 1'b0, 4'ha, 32'h52, 4'h5}, '{1'b0, 1'b0, 4'hf, 32'h43, 4'h0}};

    always #5 clk_i = ~clk_i;

    board_user_io_lcd_port u_dut (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb),
        .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat),
        .wb_ack_o(ack), .general_button_a_n_i(btn_a), .general_button_b_n_i(btn_b),
        .design_reset_button_n_i(rst_btn), .indicator_lamp_0_n_o(pins[0]),
        .indicator_lamp_1_n_o(pins[1]), .indicator_lamp_2_n_o(pins[2]),
        .indicator_lamp_3_n_o(pins[3]), .text_display_select_o(sel_o),
        .text_display_read_write_o(rw_o), .text_display_enable_o(en_o),
        .text_display_chip_select_n_o(cs_n_o), .module_data_lines_i(bus),
        .module_data_lines_o(dout), .module_data_lines_oe_n_o(oe_n));

    text_display_model u_model (.clk_i(clk_i), .select_i(sel_o), .read_write_i(rw_o),
        .enable_i(en_o), .chip_select_n_i(cs_n_o), .nibble_i(nib), .read_value_i(rdval),
        .lines_i(bus), .lines_o(model_o), .log_o(log), .sel_log_o(sel_log), .count_o(count));

    task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
        check_count++;
        if (got !== exp) begin
            n_mismatch++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, got);
        end
    endtask

    task automatic conclude();
        $display("checks %0d mismatches %0d", check_count, n_mismatch);
        if (n_mismatch == 0 && check_count > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask

    // Callers enter just after a rising edge; ack is sampled at the edge
    task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= a;
        wdat <= d;
        do begin
            @(posedge clk_i);
            n++;
        end while (ack !== 1'b1 && n < 50);
        q = rdat;
        if (n >= 50) chk("ack", 32'h1, 32'h0);
        cyc <= 1'b0;
        stb <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wait_idle();
        int n;
        n = 0;
        do begin
            wb(1'b0, OFS_XFER, 32'h0);
            n++;
        end while (q[STAT_BUSY_BIT] !== 1'b0 && n < 100);
        chk("idle", 32'h0, {31'h0, q[STAT_BUSY_BIT]});
    endtask

    always @(posedge clk_i) begin
        ticks++;
        if (ticks == 20000) begin
            n_mismatch++;
            conclude();
        end else if (!rst_i) begin
            if (en_o === 1'b1) begin
                hi_cnt++;
                if (cs_n_o !== 1'b0) chk("select in strobe", 32'h0, {31'h0, cs_n_o});
            end else if (hi_cnt != 0) begin
                chk("enable width", {24'h0, PULSE_CYC}, hi_cnt);
                hi_cnt = 0;
            end
            if (rw_o === 1'b1 && cs_n_o === 1'b0) chk("read release", 32'hff, {24'h0, oe_n});
            if (cs_n_o === 1'b1 && cs_prev === 1'b0) cs_rise++;
            cs_prev = cs_n_o;
        end
    end

    initial begin
        repeat (3) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("reset pins", {17'h0, 8'hff, 3'b100, 4'hf}, {17'h0, oe_n, cs_n_o, en_o, rw_o, pins});
        foreach (rows[i]) begin
            btn_a <= rows[i].a;
            btn_b <= rows[i].b;
            wb(1'b1, OFS_LAMP, {28'h0, rows[i].lamp});
            repeat (3) @(posedge clk_i);
            wb(1'b0, OFS_BUTTON, 32'h0);
            chk("buttons", rows[i].btn, q);
            chk("lamp pins", {28'h0, rows[i].pins}, {28'h0, pins});
        end
        wb(1'b0, 8'h20, 32'h0);
        chk("unmapped", 32'h0, q);
        // Partial byte enables: lamp and transfer writes both ignored
        sel <= 4'he;
        wb(1'b1, OFS_LAMP, 32'h0);
        wb(1'b1, OFS_XFER, 32'h0);
        wb(1'b0, OFS_XFER, 32'h0);
        sel <= 4'hf;
        chk("partial sel busy", 32'h0, {31'h0, q[STAT_BUSY_BIT]});
        chk("partial sel lamp", 32'h0, {28'h0, pins});
        for (int s = 0; s < 2; s++) begin
            c0 = count;
            wb(1'b1, OFS_XFER, {22'h0, 1'b0, s[0], 8'h3c + 8'(s)});
            wb(1'b0, OFS_XFER, 32'h0);
            chk("busy", 32'h1, {31'h0, q[STAT_BUSY_BIT]});
            // Refused while busy
            wb(1'b1, OFS_XFER, 32'h0ff);
            wait_idle();
            chk("write count", {24'h0, c0 + 8'h01}, {24'h0, count});
            chk("written byte", {23'h0, s[0], 8'h3c + 8'(s)}, {23'h0, sel_log[0], log[7:0]});
        end
        for (int m = 0; m < 2; m++) begin
            wb(1'b1, OFS_MODE, {31'h0, m[0]});
            nib <= m[0];
            rdval <= 8'h96 ^ 8'(m);
            wb(1'b1, OFS_XFER, 32'h5e);
            wait_idle();
            chk("nibble write", 32'h5e, {24'h0, log[7:0]});
            wb(1'b1, OFS_XFER, 32'h1 << XFER_RD_BIT);
            wait_idle();
            chk("read byte", {23'h0, m[0], 8'h96 ^ 8'(m)}, {23'h0, q[STAT_MODE_BIT], q[7:0]});
        end
        wb(1'b1, OFS_MODE, 32'h0);
        nib <= 1'b0;
        for (int k = 0; k < 2; k++) begin
            r0 = cs_rise;
            wb(1'b1, OFS_CHAR, {19'h0, k[0], k[0] ? 4'h5 : 4'hf, 8'h41 + 8'(k)});
            wait_idle();
            chk("char pair", {14'h0, 2'b01, 8'h80 | (k[0] ? 8'h45 : 8'h0f), 8'h41 + 8'(k)},
                {14'h0, sel_log, log});
            chk("one select", 32'h1, 32'(cs_rise - r0));
        end
        for (int k = 0; k < 2; k++) begin
            wb(1'b1, OFS_LAMP, 32'hf);
            if (k == 0) rst_btn <= 1'b0;
            else rst_i <= 1'b1;
            repeat (5) @(posedge clk_i);
            chk("lamps reset", 32'hf, {28'h0, pins});
            rst_btn <= 1'b1;
            rst_i <= 1'b0;
            repeat (5) @(posedge clk_i);
        end
        conclude();
    end
endmodule
`default_nettype wire
